// *** hw/fcis_pkg.sv ***
// fcis_pkg: constants, register map and types of the flash command host.
// assumes a 40 MHz system clock and a byte-wide asynchronous flash on pins.
package fcis_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 40;
   localparam int unsigned T_WE_LOW_NS  = 50;   // write strobe low time
   localparam int unsigned T_WE_HIGH_NS = 50;   // data hold after strobe rise
   localparam int unsigned T_ACC_NS     = 100;  // read access time
   localparam int unsigned SYNC_STAGES  = 2;
   localparam int unsigned WP_CYC  = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WPH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RD_CYC  = ACC_CYC + SYNC_STAGES + 2;
   // give-up limit for status polling, in cycles (5 s at 40 MHz)
   localparam logic [31:0] POLL_LIMIT_DEF = 32'd200000000;

   // ------------------------------------------------------------------
   // flash bus and command bytes
   // ------------------------------------------------------------------
   localparam int unsigned AW = 19;
   localparam int unsigned DW = 8;
   localparam logic [18:0] UNLOCK1_ADDR    = 19'h05555;
   localparam logic [7:0]  UNLOCK1_DATA    = 8'haa;
   localparam logic [18:0] UNLOCK2_ADDR    = 19'h02aaa;
   localparam logic [7:0]  UNLOCK2_DATA    = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
   localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0]  CMD_BLOCK_ERASE = 8'h30;
   localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
   localparam logic [7:0]  CMD_READ_ARRAY  = 8'hf0;
   localparam logic [2:0]  LAST_PROGRAM    = 3'd3;
   localparam logic [2:0]  LAST_ERASE      = 3'd5;
   localparam logic [2:0]  LAST_RESET      = 3'd2;

   // status byte of the flash
   localparam int unsigned POLLING_BIT     = 7;
   localparam int unsigned TOGGLE_BIT      = 6;
   localparam int unsigned ERROR_BIT       = 5;
   localparam int unsigned ERASE_TIMER_BIT = 3;
   localparam logic [7:0]  STAT_MASK       = 8'he8;

   // ------------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------------
   localparam logic [7:0]  OFS_CMD    = 8'h00;
   localparam logic [7:0]  OFS_ADDR   = 8'h04;
   localparam logic [7:0]  OFS_WDATA  = 8'h08;
   localparam logic [7:0]  OFS_STATUS = 8'h0c;
   localparam logic [7:0]  OFS_RDATA  = 8'h10;
   localparam logic [18:0] ADDR_RST   = 19'h00000;
   localparam logic [7:0]  WDATA_RST  = 8'hff;
   localparam int unsigned ST_BUSY    = 0;
   localparam int unsigned ST_DONE    = 1;
   localparam int unsigned ST_FAIL    = 2;
   localparam int unsigned ST_TMO     = 3;
   localparam int unsigned ST_BYTE    = 8;

   typedef enum logic [2:0] {
      OP_READ        = 3'b000,
      OP_PROGRAM     = 3'b001,
      OP_BLOCK_ERASE = 3'b010,
      OP_CHIP_ERASE  = 3'b011,
      OP_RESET       = 3'b100
   } fcis_op_type;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_WSET  = 3'b001,
      S_WLOW  = 3'b010,
      S_WHIGH = 3'b011,
      S_RLOW  = 3'b100,
      S_RCHK  = 3'b101
   } fcis_state_type;

endpackage

// *** hw/fcis_sync.sv ***
// fcis_sync: two-stage synchroniser for the flash data pins.
// assumes the pins change outside sys_clk_i timing; two flops per bit.
`timescale 1ns/100ps
module fcis_sync
   import fcis_pkg::*;
(
   input  wire logic          sys_clk_i,
   input  wire logic          nrst_i,
   input  wire logic [DW-1:0] pin_i,
   output logic      [DW-1:0] sync_o
);

   // ------------------------------------------------------------------
   // per-bit double flop; the first stage feeds only the second
   // ------------------------------------------------------------------
   logic [DW-1:0] meta_q;

   for (genvar b = 0; b < DW; b++) begin : g_bit
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            meta_q[b] <= 1'b0;
            sync_o[b] <= 1'b0;
         end else begin
            meta_q[b] <= pin_i[b];
            sync_o[b] <= meta_q[b];
         end
      end
   end

endmodule

// *** hw/fcis_host.sv ***
// fcis_host: host controller that drives a byte-wide flash command interface.
// assumes the flash pins connect directly; software uses a simple strobe port.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module fcis_host
   import fcis_pkg::*;
#(
   parameter logic [31:0] POLL_LIMIT = POLL_LIMIT_DEF
)(
   input  wire logic          sys_clk_i,
   input  wire logic          nrst_i,
   input  wire logic [7:0]    reg_addr_i,
   input  wire logic [31:0]   reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic      [31:0]   reg_rdata_o,
   output logic      [AW-1:0] flash_addr_o,
   output logic      [DW-1:0] flash_dq_o,
   output logic               flash_dq_oe_n_o,
   input  wire logic [DW-1:0] flash_dq_i,
   output logic               flash_ce_n_o,
   output logic               flash_we_n_o,
   output logic               flash_oe_n_o
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   fcis_state_type  state_q;
   fcis_op_type     op_q;
   logic [3:0]      cnt_q;
   logic [2:0]      step_q;
   logic [2:0]      last_step;
   logic [AW-1:0]   addr_q;
   logic [DW-1:0]   wdata_q;
   logic [DW-1:0]   dq_sync;
   logic [DW-1:0]   rd_byte_q;
   logic [DW-1:0]   stat_q;
   logic [DW-1:0]   rdata_q;
   logic [31:0]     poll_cnt_q;
   logic            busy_q;
   logic            done_q;
   logic            fail_q;
   logic            tmo_q;
   logic            err_seen_q;
   logic            start;
   logic            op_ok;
   logic            is_erase;
   logic            exp_bit;
   logic [AW-1:0]   lk_addr;
   logic [DW-1:0]   lk_data;

   fcis_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .pin_i     (flash_dq_i),
      .sync_o    (dq_sync)
   );

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   // undefined op codes never start anything
   assign op_ok    = (reg_wdata_i[2:0] <= OP_RESET);
   assign start    = reg_wr_i && (reg_addr_i == OFS_CMD) && !busy_q && op_ok;
   assign is_erase = (op_q == OP_BLOCK_ERASE) || (op_q == OP_CHIP_ERASE);
   // expected polling bit once finished: data bit for program, one for erase
   assign exp_bit  = (op_q == OP_PROGRAM) ? wdata_q[POLLING_BIT] : 1'b1;

   // last write step of each instruction
   assign last_step = (op_q == OP_PROGRAM) ? LAST_PROGRAM :
                      (is_erase ? LAST_ERASE : LAST_RESET);

   // address and byte of each write cycle of the instruction
   always_comb begin
      lk_addr = UNLOCK1_ADDR;
      lk_data = UNLOCK1_DATA;
      unique case (step_q)
         3'd0, 3'd3: begin
            if (op_q == OP_PROGRAM && step_q == 3'd3) begin
               lk_addr = addr_q;
               lk_data = wdata_q;
            end
         end
         3'd1, 3'd4: begin
            lk_addr = UNLOCK2_ADDR;
            lk_data = UNLOCK2_DATA;
         end
         3'd2: begin
            unique case (op_q)
               OP_PROGRAM:                    lk_data = CMD_PROGRAM;
               OP_BLOCK_ERASE, OP_CHIP_ERASE: lk_data = CMD_ERASE_SETUP;
               default:                       lk_data = CMD_READ_ARRAY;
            endcase
         end
         default: begin
            // erase confirm: block address or chip-wide code
            lk_addr = (op_q == OP_BLOCK_ERASE) ? addr_q : UNLOCK1_ADDR;
            lk_data = (op_q == OP_BLOCK_ERASE) ? CMD_BLOCK_ERASE : CMD_CHIP_ERASE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // bus sequencer: write cycles, then status polling reads
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q         <= S_IDLE;
         op_q            <= OP_READ;
         cnt_q           <= 4'h0;
         step_q          <= 3'h0;
         busy_q          <= 1'b0;
         done_q          <= 1'b0;
         fail_q          <= 1'b0;
         tmo_q           <= 1'b0;
         err_seen_q      <= 1'b0;
         rd_byte_q       <= 8'h00;
         stat_q          <= 8'h00;
         rdata_q         <= 8'h00;
         flash_addr_o    <= ADDR_RST;
         flash_dq_o      <= 8'h00;
         flash_dq_oe_n_o <= 1'b1;
         flash_ce_n_o    <= 1'b1;
         flash_we_n_o    <= 1'b1;
         flash_oe_n_o    <= 1'b1;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (start) begin
                  op_q       <= fcis_op_type'(reg_wdata_i[2:0]);
                  step_q     <= 3'h0;
                  cnt_q      <= 4'h0;
                  busy_q     <= 1'b1;
                  done_q     <= 1'b0;
                  fail_q     <= 1'b0;
                  tmo_q      <= 1'b0;
                  err_seen_q <= 1'b0;
                  // plain reads need no command; all else opens with writes
                  state_q    <= (reg_wdata_i[2:0] == OP_READ) ? S_RLOW : S_WSET;
               end
            end
            S_WSET: begin
               flash_addr_o    <= lk_addr;
               flash_dq_o      <= lk_data;
               flash_dq_oe_n_o <= 1'b0;
               flash_ce_n_o    <= 1'b0;
               state_q         <= S_WLOW;
            end
            S_WLOW: begin
               // address is stable before the strobe falls
               flash_we_n_o <= 1'b0;
               if (cnt_q == 4'(WP_CYC - 1)) begin
                  cnt_q   <= 4'h0;
                  state_q <= S_WHIGH;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            S_WHIGH: begin
               // data kept driven past the rising strobe
               flash_we_n_o <= 1'b1;
               if (cnt_q == 4'(WPH_CYC - 1)) begin
                  cnt_q           <= 4'h0;
                  flash_ce_n_o    <= 1'b1;
                  flash_dq_oe_n_o <= 1'b1;
                  if (step_q != last_step) begin
                     step_q  <= step_q + 3'h1;
                     state_q <= S_WSET;
                  end else if (op_q == OP_RESET) begin
                     busy_q  <= 1'b0;
                     done_q  <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_RLOW;
                  end
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            S_RLOW: begin
               // polls stay on the target address of the instruction
               flash_addr_o    <= addr_q;
               flash_dq_oe_n_o <= 1'b1;
               flash_ce_n_o    <= 1'b0;
               flash_oe_n_o    <= 1'b0;
               if (cnt_q == 4'(RD_CYC - 1)) begin
                  cnt_q     <= 4'h0;
                  rd_byte_q <= dq_sync;
                  state_q   <= S_RCHK;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            S_RCHK: begin
               // strobes released so the next read is a fresh edge
               flash_ce_n_o <= 1'b1;
               flash_oe_n_o <= 1'b1;
               if (op_q == OP_READ) begin
                  rdata_q <= rd_byte_q;
                  busy_q  <= 1'b0;
                  done_q  <= 1'b1;
                  state_q <= S_IDLE;
               end else begin
                  stat_q <= rd_byte_q & STAT_MASK;
                  if (rd_byte_q[POLLING_BIT] == exp_bit) begin
                     rdata_q <= rd_byte_q;
                     busy_q  <= 1'b0;
                     done_q  <= 1'b1;
                     state_q <= S_IDLE;
                  end else if (poll_cnt_q >= POLL_LIMIT ||
                               (rd_byte_q[ERROR_BIT] && err_seen_q)) begin
                     // stuck poll or real error: a read-array reset clears the flag
                     tmo_q   <= (poll_cnt_q >= POLL_LIMIT);
                     fail_q  <= 1'b1;
                     op_q    <= OP_RESET;
                     step_q  <= 3'h0;
                     state_q <= S_WSET;
                  end else begin
                     // error needs a second read: polling may flip at that moment
                     err_seen_q <= err_seen_q | rd_byte_q[ERROR_BIT];
                     state_q    <= S_RLOW;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // software writes of target address and data byte
   // ------------------------------------------------------------------
   // changes are refused while busy so polls keep one address
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr_q  <= ADDR_RST;
         wdata_q <= WDATA_RST;
      end else if (reg_wr_i && !busy_q && reg_addr_i == OFS_ADDR) begin
         addr_q <= reg_wdata_i[AW-1:0];
      end else if (reg_wr_i && !busy_q && reg_addr_i == OFS_WDATA) begin
         wdata_q <= reg_wdata_i[DW-1:0];
      end
   end

   // ------------------------------------------------------------------
   // poll time budget
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         poll_cnt_q <= 32'h0;
      end else if (state_q == S_IDLE || state_q == S_WSET) begin
         poll_cnt_q <= 32'h0;
      end else if (poll_cnt_q != 32'hffffffff) begin
         poll_cnt_q <= poll_cnt_q + 32'h1;
      end
   end

   // ------------------------------------------------------------------
   // register read port, data one cycle after the strobe
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 32'h0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_CMD:    reg_rdata_o <= {29'h0, op_q};
            OFS_ADDR:   reg_rdata_o <= {13'h0, addr_q};
            OFS_WDATA:  reg_rdata_o <= {24'h0, wdata_q};
            OFS_STATUS: reg_rdata_o <= {16'h0, stat_q, 4'h0, tmo_q, fail_q, done_q, busy_q};
            OFS_RDATA:  reg_rdata_o <= {24'h0, rdata_q};
            default:    reg_rdata_o <= 32'h0;
         endcase
      end else begin
         reg_rdata_o <= 32'h0;
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   a_strobe_excl: assert property (!(!flash_we_n_o && !flash_oe_n_o))
      else $error("write and output strobes low together");
   a_we_in_ce: assert property (!flash_we_n_o |-> !flash_ce_n_o)
      else $error("write strobe low without chip enable");
   a_write_hold: assert property (!flash_we_n_o |=>
                                  $stable(flash_dq_o) && $stable(flash_addr_o)
                                  && !flash_dq_oe_n_o)
      else $error("address or data moved around the write strobe");
   a_we_pulse_len: assert property ($fell(flash_we_n_o) |=> !flash_we_n_o ##1 flash_we_n_o)
      else $error("write strobe pulse length wrong");
   a_read_release: assert property (!flash_oe_n_o |-> flash_dq_oe_n_o)
      else $error("host drives data during a read");
   a_unlock_first: assert property ($fell(flash_we_n_o) && step_q == 3'd0 |->
                                    flash_addr_o == UNLOCK1_ADDR && flash_dq_o == UNLOCK1_DATA)
      else $error("first unlock cycle wrong");
   a_unlock_second: assert property ($fell(flash_we_n_o) && step_q == 3'd1 |->
                                     flash_addr_o == UNLOCK2_ADDR && flash_dq_o == UNLOCK2_DATA)
      else $error("second unlock cycle wrong");
   a_erase_relock: assert property ($fell(flash_we_n_o) && is_erase && step_q == 3'd4 |->
                                    flash_addr_o == UNLOCK2_ADDR && flash_dq_o == UNLOCK2_DATA
                                    && $past(flash_dq_o, 2) == UNLOCK1_DATA)
      else $error("erase confirm not preceded by unlock");
   a_poll_addr: assert property ($fell(flash_oe_n_o) && op_q != OP_RESET |->
                                 flash_addr_o == addr_q)
      else $error("poll read away from target address");
   a_fail_reset: assert property ($rose(fail_q) |-> op_q == OP_RESET ##[1:20] !flash_we_n_o)
      else $error("failure not followed by reset writes");
   a_status_read: assert property (reg_rd_i && reg_addr_i == OFS_STATUS |=>
                                   reg_rdata_o[ST_BUSY] == $past(busy_q))
      else $error("status read data wrong");

   c_program_done: cover property (op_q == OP_PROGRAM && $rose(done_q));
   c_erase_done:   cover property (op_q == OP_BLOCK_ERASE && $rose(done_q));
   c_fail:         cover property ($rose(fail_q));
   c_plain_read:   cover property (op_q == OP_READ && $rose(done_q));

endmodule

// *** verification/fcis_flash_model.sv ***
// fcis_flash_model: behavioural byte-wide flash on the far side of the host.
// assumes host strobes on its pins; busy time is counted in status reads.
`timescale 1ns/100ps
module fcis_flash_model
   import fcis_pkg::*;
#(
   parameter int BUSY_READS = 3
)(
   input  wire logic [18:0] addr_i,
   input  wire logic [7:0]  dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        fault_i,
   input  wire logic        protect_i,
   output logic      [7:0]  dq_o
);
   logic [7:0]  mem [logic [18:0]];
   logic [18:0] la;
   logic [18:0] pa;
   logic [7:0]  pd;
   logic [7:0]  cmd;
   logic [7:0]  v;
   logic [7:0]  rd_q = 8'h00;
   logic        busy = 1'b0;
   logic        er = 1'b0;
   logic        tog = 1'b0;
   logic        err = 1'b0;
   logic        nop = 1'b0;
   int          step = 0;
   int          cnt = 0;

   function automatic logic [7:0] rdm(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction

   task automatic start(input logic e);
      if (protect_i && !e) return;
      busy = 1'b1;
      er = e;
      nop = protect_i; // protected erase only polls, nothing is cleared
      pa = la;
      pd = dq_i;
      cnt = BUSY_READS;
      tog = 1'b0;
   endtask

   // --------------------------------------------------------------
   // command interface
   // --------------------------------------------------------------
   // address taken on the strobe fall, data on its rise
   always @(negedge we_n_i) if (!ce_n_i) la = addr_i;

   // unlock, command and confirm decoding; anything else drops to read
   always @(posedge we_n_i) if (!ce_n_i) begin
      case (step)
         0: step = (dq_i == 8'haa && la == 19'h05555) ? 1 : 0;
         1: step = (dq_i == 8'h55 && la == 19'h02aaa) ? 2 : 0;
         2: begin
            cmd = dq_i;
            step = (la == 19'h05555 && (cmd == 8'ha0 || cmd == 8'h80)) ? 3 : 0;
            if (la == 19'h05555 && cmd == 8'hf0) begin
               busy = 1'b0;
               err = 1'b0;
            end
         end
         3: begin
            step = (cmd == 8'h80 && dq_i == 8'haa && la == 19'h05555) ? 4 : 0;
            if (cmd == 8'ha0) start(1'b0);
         end
         4: step = (dq_i == 8'h55 && la == 19'h02aaa) ? 5 : 0;
         5: begin
            step = 0;
            if (dq_i == 8'h30 || (dq_i == 8'h10 && la == 19'h05555)) start(1'b1);
         end
         default: step = 0;
      endcase
   end

   // --------------------------------------------------------------
   // read path
   // --------------------------------------------------------------
   // busy reads give status; block erase clears all, a known shortcut
   // both strobes fall in one time step; wake on either so no order is assumed
   always @(negedge oe_n_i or negedge ce_n_i) if (!ce_n_i && !oe_n_i) begin
      if (busy && cnt > 0) begin
         tog = ~tog;
         if (fault_i) err = 1'b1;
         else cnt = cnt - 1;
         // reserved bits carry junk so the host must mask them
         v = {er ? 1'b0 : ~pd[7], tog, err, 1'b1, ~(er && cnt >= BUSY_READS - 1), 3'b011};
      end else begin
         if (busy && er && !nop) mem.delete();
         if (busy && !er) mem[pa] = rdm(pa) & pd;
         busy = 1'b0;
         v = rdm(addr_i);
      end
      rd_q <= #60 v;
   end
   // released bus shows the inverse of the last value
   assign dq_o = (!ce_n_i && !oe_n_i) ? rd_q : ~rd_q;
endmodule

// *** verification/flash_command_interface_status_tb.sv ***
// flash_command_interface_status_tb: register-level tests of the flash host.
// assumes the flash model on the pins and a shortened poll limit.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module flash_command_interface_status_tb;
   import fcis_pkg::*;
   logic        sys_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic [31:0] reg_rdata_o;
   logic [31:0] s;
   logic [18:0] fa;
   logic [7:0]  dqo;
   logic [7:0]  dqi;
   logic        dq_oe_n, ce_n, we_n, oe_n;
   logic        fault = 1'b0;
   logic        prot = 1'b0;
   int          checked = 0;
   int          fail_count = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   fcis_host #(.POLL_LIMIT(32'd2000)) DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .flash_addr_o(fa),
      .flash_dq_o(dqo), .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dqi),
      .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n));
   fcis_flash_model FLASH (.addr_i(fa), .dq_i(dqo), .ce_n_i(ce_n), .we_n_i(we_n),
      .oe_n_i(oe_n), .fault_i(fault), .protect_i(prot), .dq_o(dqi));

   // --------------------------------------------------------------
   // register port tasks
   // --------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   // start an op, try to move ADDR while busy, poll status to the end
   task automatic run(input logic [2:0] op, input logic [3:0] e);
      int n;
      wr(OFS_CMD, {29'h0, op});
      wr(OFS_ADDR, 32'h00077);
      n = 0;
      do begin
         rd(OFS_STATUS, s);
         n++;
      end while (s[ST_BUSY] === 1'b1 && n < 5000);
      `CHK("status", e, s[3:0])
   endtask

   task automatic stop_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // watchdog sized well above the longest poll timeout
   initial begin
      repeat (30000) @(posedge sys_clk_i);
      fail_count++;
      stop_test();
   end

   // --------------------------------------------------------------
   // test sequence
   // --------------------------------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rd(OFS_WDATA, s);
      `CHK("wdata", {24'h0, WDATA_RST}, s)
      rd(8'h14, s);
      `CHK("unmapped", 32'h0, s)
      `CHK("ce_n", 1'b1, ce_n)
      `CHK("we_n", 1'b1, we_n)
      `CHK("oe_n", 1'b1, oe_n)
      `CHK("dq_oe_n", 1'b1, dq_oe_n)
      wr(OFS_ADDR, 32'h12345);
      wr(OFS_WDATA, 32'h5a);
      run(OP_PROGRAM, 4'b0010);
      rd(OFS_ADDR, s);
      `CHK("addr", 32'h00012345, s)
      run(OP_READ, 4'b0010);
      rd(OFS_RDATA, s);
      `CHK("rdata", 32'h5a, s)
      fault <= 1'b1;
      run(OP_PROGRAM, 4'b0110);
      `CHK("errbit", 1'b1, s[8+ERROR_BIT])
      `CHK("reserved", 8'h00, s[15:8] & ~STAT_MASK)
      fault <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         run(k ? OP_CHIP_ERASE : OP_BLOCK_ERASE, 4'b0010);
         run(OP_READ, 4'b0010);
         rd(OFS_RDATA, s);
         `CHK("erased", 32'hff, s)
         run(OP_PROGRAM, 4'b0010);
      end
      // protected byte: polling never matches, so only the limit ends it
      prot <= 1'b1;
      wr(OFS_WDATA, 32'h80);
      run(OP_PROGRAM, 4'b1110);
      run(OP_BLOCK_ERASE, 4'b1110);
      prot <= 1'b0;
      run(OP_READ, 4'b0010);
      rd(OFS_RDATA, s);
      `CHK("protected", 32'h5a, s)
      run(OP_RESET, 4'b0010);
      wr(OFS_CMD, 32'h7);
      rd(OFS_STATUS, s);
      `CHK("refused", 2'b10, s[1:0])
      stop_test();
   end
endmodule
